// ===== verilog/bac_defs.svh
// constants of the billboard attach control block: offsets, fields, resets, times
// assumes a single 125 MHz system clock and an AHB-Lite register port
//
// What this block does
// RL1 - control bit 0 enables billboard support; 0 disables it entirely.
// RL2 - five-bit field picks the failure pin; default picks default_fail_pin; one code reserved.
// RL3 - failure input is active low; low means alternate-mode negotiation failed.
// RL4 - on failure low, first detach the internal controller device from the hub port.
// RL5 - then reconnect it presenting billboard class 1.1 descriptors.
// RL6 - first detach timer starts on address assignment; default timeout 20 seconds.
// RL7 - billboard shown only after modal failure; configured field reports unspecified error by default.
// RL8 - alternate-mode string request is answered and starts the second detach timer, default 20 s.
// RL9 - expiry of either timer detaches the billboard device from the hub port.
// RL10 - after that detach, reconnect with standard controller descriptors and function.
// RL11 - each timer is sixteen bits over low and high byte registers, 10 ms steps.
// RL12 - timer default is low d0, high 07: 2000 steps, 20 seconds.
// RL13 - failure message in billboard descriptors comes from one-time-programmable memory.
// RL14 - with enable at 0, ignore the failure pin and keep the standard role.
// RL15 - a new billboard session needs the failure input high, then low again.
// RL16 - timers count a 10 ms tick from the clock; expire when count equals setting.
`ifndef BAC_DEFS_SVH
`define BAC_DEFS_SVH

// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define BAC_IDX_CONTROL      18'h00004
`define BAC_IDX_ADDR_TMO_LO  18'h0413c
`define BAC_IDX_ADDR_TMO_HI  18'h0413d
`define BAC_IDX_STR_TMO_LO   18'h0413e
`define BAC_IDX_STR_TMO_HI   18'h0413f
`define BAC_IDX_DESC_CFG     18'h04140
`define BAC_IDX_STATUS       18'h04141

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define BAC_CTRL_EN_BIT      0
`define BAC_CTRL_SEL_LSB     1
`define BAC_CTRL_SEL_MSB     5
`define BAC_CTRL_RESET       8'h14
`define BAC_SEL_RESERVED     5'h09
`define BAC_TMO_LO_RESET     8'hd0
`define BAC_TMO_HI_RESET     8'h07
`define BAC_BMCFG_RESET      2'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define BAC_CLK_KHZ          125000
`define BAC_TICK_MS          10
`define BAC_DETACH_HOLD_US   100

`endif

// ===== verilog/bac_pkg.sv
// types of the billboard attach control block
// assumes nothing beyond a SystemVerilog tool
`default_nettype none

package bac_pkg;
	typedef enum logic [2:0] {
		BAC_ST_NORMAL,
		BAC_ST_DETACH_BB,
		BAC_ST_BILLBOARD,
		BAC_ST_DETACH_STD
	} bac_state_e;
endpackage : bac_pkg

`default_nettype wire

// ===== verilog/bac_sync.sv
// two-flop synchroniser for a bus of independent levels
// assumes inputs idle high (active-low pins)
`default_nettype none

module bac_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_reg <= '1;
			q        <= '1;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule : bac_sync

`default_nettype wire

// ===== verilog/bac_detach_timer.sv
// one detach timer counting 10 ms ticks up to a sixteen-bit setting
// assumes tick is a one-cycle pulse from the shared tick divider
`default_nettype none

module bac_detach_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// control
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic         tick,
	input  wire logic [W-1:0] limit,
	// status
	output logic              running,
	output logic              expired
);
	logic [W-1:0] count_reg;

	// restart while running is ignored so a repeated request cannot stretch the session
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			running   <= 1'b0;
			count_reg <= '0;
			expired   <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (stop) begin
				running <= 1'b0;
			end else if (start && !running) begin
				running   <= 1'b1;
				count_reg <= '0;
			end else if (running && count_reg == limit) begin // [RL16]
				running <= 1'b0;
				expired <= 1'b1;
			end else if (running && tick) begin
				count_reg <= count_reg + 1'b1; // [RL11]
			end
		end
	end
endmodule : bac_detach_timer

`default_nettype wire

// ===== verilog/bac_top.sv
// billboard attach control: swaps the internal controller device into a
// billboard device on an external failure pin, and back on timer expiry
// assumes hub-side pulses are on hclk; gpio pins are asynchronous
`default_nettype none
`include "bac_defs.svh"

module bac_top #(
	parameter int NUM_GPIO    = 72,
	parameter int TICK_CYCLES = `BAC_TICK_MS * `BAC_CLK_KHZ,
	parameter int HOLD_CYCLES = `BAC_DETACH_HOLD_US * `BAC_CLK_KHZ / 1000
) (
	// clock and reset
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic      [31:0]         hrdata,
	output logic                     hresp,
	// general-purpose pins, failure input among them
	input  wire logic [NUM_GPIO-1:0] gpio_in,
	// hub feature controller events
	input  wire logic                usb_addr_set,
	input  wire logic                alt_string_req,
	// hub feature controller steering
	output logic                     dev_connect,
	output logic                     billboard_mode,
	output logic                     alt_string_ack,
	output logic                     otp_msg_sel,
	output logic      [1:0]          bm_configured
);
	// ----------------------------------------
	// pin selection
	// ----------------------------------------
	// maps the select code to a gpio number; bit 7 flags a usable code
	function automatic logic [7:0] pin_of(input logic [4:0] sel);
		logic [7:0] r;
		r = 8'h00;
		unique case (sel)
			5'h00: r = {1'b1, 7'd64};
			5'h01: r = {1'b1, 7'd1};
			5'h02: r = {1'b1, 7'd2};
			5'h03: r = {1'b1, 7'd3};
			5'h04: r = {1'b1, 7'd65};
			5'h05: r = {1'b1, 7'd66};
			5'h06: r = {1'b1, 7'd67};
			5'h07: r = {1'b1, 7'd23};
			5'h08: r = {1'b1, 7'd10};
			5'h0a: r = {1'b1, 7'd68};
			5'h0b: r = {1'b1, 7'd6};
			5'h0c: r = {1'b1, 7'd69};
			5'h0d: r = {1'b1, 7'd70};
			5'h0e: r = {1'b1, 7'd71};
			5'h0f: r = {1'b1, 7'd5};
			5'h10: r = {1'b1, 7'd4};
			default: r = 8'h00;
		endcase
		return r;
	endfunction : pin_of

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] control_reg;
	logic [7:0] addr_tmo_lo_reg;
	logic [7:0] addr_tmo_hi_reg;
	logic [7:0] str_tmo_lo_reg;
	logic [7:0] str_tmo_hi_reg;
	logic [1:0] bmcfg_reg;

	logic       enable;
	logic [4:0] pin_sel;
	logic [7:0] pin_map;
	assign enable  = control_reg[`BAC_CTRL_EN_BIT]; // [RL1]
	assign pin_sel = control_reg[`BAC_CTRL_SEL_MSB:`BAC_CTRL_SEL_LSB]; // [RL2]
	assign pin_map = pin_of(pin_sel);

	// ----------------------------------------
	// pin synchroniser and failure level
	// ----------------------------------------
	logic [NUM_GPIO-1:0] gpio_sync;
	logic                fail_low;

	bac_sync #(
		.W (NUM_GPIO)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.d       (gpio_in),
		.q       (gpio_sync)
	);

	// a reserved or out-of-range code reads as an idle-high pin
	always_comb begin
		fail_low = 1'b0;
		if (pin_map[7] && int'(pin_map[6:0]) < NUM_GPIO) begin
			fail_low = !gpio_sync[pin_map[6:0]]; // [RL3]
		end
	end

	// ----------------------------------------
	// 10 ms tick and detach hold counters
	// ----------------------------------------
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	logic [TW-1:0] tick_cnt_reg;
	logic          tick;
	logic [HW-1:0] hold_cnt_reg;
	logic          hold_done;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_reg <= '0;
			tick         <= 1'b0;
		end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= '0;
			tick         <= 1'b1; // [RL16]
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			tick         <= 1'b0;
		end
	end

	// ----------------------------------------
	// session state machine
	// ----------------------------------------
	bac_pkg::bac_state_e state_reg;
	bac_pkg::bac_state_e state_next;
	logic                armed_reg;
	logic                tmr_a_exp;
	logic                tmr_b_exp;
	logic                tmr_a_run;
	logic                tmr_b_run;
	logic                in_bb;

	assign in_bb     = (state_reg == bac_pkg::BAC_ST_BILLBOARD);
	assign hold_done = (hold_cnt_reg == HW'(HOLD_CYCLES - 1));

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			bac_pkg::BAC_ST_NORMAL: begin
				if (enable && armed_reg && fail_low) begin // [RL14]
					state_next = bac_pkg::BAC_ST_DETACH_BB; // [RL4]
				end
			end
			bac_pkg::BAC_ST_DETACH_BB: begin
				if (hold_done) begin
					state_next = bac_pkg::BAC_ST_BILLBOARD; // [RL5]
				end
			end
			bac_pkg::BAC_ST_BILLBOARD: begin
				if (tmr_a_exp || tmr_b_exp || !enable) begin // [RL9] [RL14]
					state_next = bac_pkg::BAC_ST_DETACH_STD;
				end
			end
			bac_pkg::BAC_ST_DETACH_STD: begin
				if (hold_done) begin
					state_next = bac_pkg::BAC_ST_NORMAL; // [RL10]
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= bac_pkg::BAC_ST_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// hold counter runs only while the device is forced off the port
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_cnt_reg <= '0;
		end else if (state_next != state_reg) begin
			hold_cnt_reg <= '0;
		end else if (state_reg == bac_pkg::BAC_ST_DETACH_BB ||
				state_reg == bac_pkg::BAC_ST_DETACH_STD) begin
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
		end
	end

	// a session consumes the low level; the pin must rise before the next one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_reg <= 1'b1;
		end else if (!fail_low) begin
			armed_reg <= 1'b1; // [RL15]
		end else if (state_reg == bac_pkg::BAC_ST_DETACH_BB) begin
			armed_reg <= 1'b0; // [RL15]
		end
	end

	// ----------------------------------------
	// detach timers
	// ----------------------------------------
	bac_detach_timer #(
		.W (16)
	) u_tmr_addr (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (in_bb && usb_addr_set), // [RL6]
		.stop    (!in_bb),
		.tick    (tick),
		.limit   ({addr_tmo_hi_reg, addr_tmo_lo_reg}),
		.running (tmr_a_run),
		.expired (tmr_a_exp)
	);

	bac_detach_timer #(
		.W (16)
	) u_tmr_str (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (in_bb && alt_string_req), // [RL8]
		.stop    (!in_bb),
		.tick    (tick),
		.limit   ({str_tmo_hi_reg, str_tmo_lo_reg}),
		.running (tmr_b_run),
		.expired (tmr_b_exp)
	);

	// ----------------------------------------
	// device steering outputs
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_connect    <= 1'b1;
			billboard_mode <= 1'b0;
			alt_string_ack <= 1'b0;
			otp_msg_sel    <= 1'b0;
			bm_configured  <= `BAC_BMCFG_RESET;
		end else begin
			dev_connect    <= (state_next == bac_pkg::BAC_ST_NORMAL ||
					state_next == bac_pkg::BAC_ST_BILLBOARD); // [RL4] [RL9]
			billboard_mode <= (state_next == bac_pkg::BAC_ST_BILLBOARD); // [RL5] [RL10]
			alt_string_ack <= in_bb && alt_string_req; // [RL8]
			otp_msg_sel    <= (state_next == bac_pkg::BAC_ST_BILLBOARD); // [RL13]
			bm_configured  <= bmcfg_reg; // [RL7]
		end
	end

	// ----------------------------------------
	// ahb-lite slave
	// ----------------------------------------
	// reads take one wait state so read data always comes from a flop
	logic        wr_pend_reg;
	logic        rd_wait_reg;
	logic [17:0] idx_reg;
	logic        accept;
	logic [17:0] idx_in;
	logic        idx_ok;

	assign accept    = hsel && htrans[1] && hready;
	assign idx_in    = haddr[19:2];
	assign idx_ok    = (haddr[31:20] == 12'h000) && (haddr[1:0] == 2'b00);
	assign hreadyout = !rd_wait_reg;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			idx_reg     <= '0;
		end else begin
			wr_pend_reg <= accept && hwrite && idx_ok;
			rd_wait_reg <= accept && !hwrite;
			if (accept) begin
				idx_reg <= idx_ok ? idx_in : 18'h3ffff;
			end
		end
	end

	logic [7:0] status;
	assign status = {tmr_b_run, tmr_a_run, armed_reg, fail_low,
			pin_map[7], state_reg};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (rd_wait_reg) begin
			unique case (idx_reg)
				`BAC_IDX_CONTROL:     hrdata <= {24'h0, 2'b00, control_reg[5:0]};
				`BAC_IDX_ADDR_TMO_LO: hrdata <= {24'h0, addr_tmo_lo_reg};
				`BAC_IDX_ADDR_TMO_HI: hrdata <= {24'h0, addr_tmo_hi_reg};
				`BAC_IDX_STR_TMO_LO:  hrdata <= {24'h0, str_tmo_lo_reg};
				`BAC_IDX_STR_TMO_HI:  hrdata <= {24'h0, str_tmo_hi_reg};
				`BAC_IDX_DESC_CFG:    hrdata <= {30'h0, bmcfg_reg};
				`BAC_IDX_STATUS:      hrdata <= {24'h0, status};
				default:              hrdata <= '0;
			endcase
		end
	end

	// writes land in the data phase; a reserved pin code keeps the old select
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_reg     <= `BAC_CTRL_RESET;
			addr_tmo_lo_reg <= `BAC_TMO_LO_RESET; // [RL12]
			addr_tmo_hi_reg <= `BAC_TMO_HI_RESET; // [RL12]
			str_tmo_lo_reg  <= `BAC_TMO_LO_RESET; // [RL12]
			str_tmo_hi_reg  <= `BAC_TMO_HI_RESET; // [RL12]
			bmcfg_reg       <= `BAC_BMCFG_RESET; // [RL7]
		end else if (wr_pend_reg) begin
			unique case (idx_reg)
				`BAC_IDX_CONTROL: begin
					control_reg[0] <= hwdata[0]; // [RL1]
					if (hwdata[5:1] != `BAC_SEL_RESERVED) begin
						control_reg[5:1] <= hwdata[5:1]; // [RL2]
					end
				end
				`BAC_IDX_ADDR_TMO_LO: addr_tmo_lo_reg <= hwdata[7:0]; // [RL11]
				`BAC_IDX_ADDR_TMO_HI: addr_tmo_hi_reg <= hwdata[7:0]; // [RL11]
				`BAC_IDX_STR_TMO_LO:  str_tmo_lo_reg  <= hwdata[7:0]; // [RL11]
				`BAC_IDX_STR_TMO_HI:  str_tmo_hi_reg  <= hwdata[7:0]; // [RL11]
				`BAC_IDX_DESC_CFG:    bmcfg_reg       <= hwdata[1:0];
				default: ;
			endcase
		end
	end

	// hsize is accepted but only whole-word transfers are meaningful
	logic unused_ok;
	assign unused_ok = &{1'b0, hsize, hwdata[31:8]};
endmodule : bac_top

`default_nettype wire

// ===== sim/bac_monitor.sv
// checker of the billboard attach control top ports
// assumes a single hclk domain with hresetn async active low
`default_nettype none

module bac_monitor #(
	parameter int HOLD_CYCLES = 8
) (
	// clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// bus
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hwrite,
	input wire logic       hready,
	input wire logic       hreadyout,
	input wire logic       hresp,
	// hub side
	input wire logic       alt_string_req,
	input wire logic       alt_string_ack,
	input wire logic       dev_connect,
	input wire logic       billboard_mode,
	input wire logic       otp_msg_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] low_cnt;

	// ----
	// detach length counter
	// ----
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			low_cnt <= 16'h0;
		else if (dev_connect)
			low_cnt <= 16'h0;
		else
			low_cnt <= low_cnt + 16'h1;
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_read_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> s_read_wait)
		else $error("read without one wait state");
	a_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_otp_mode: assert property (otp_msg_sel == billboard_mode)
		else $error("message select differs from mode");
	a_ack_cause: assert property (alt_string_ack |-> $past(alt_string_req))
		else $error("string ack without request");
	a_ack_given: assert property (alt_string_req && billboard_mode |=> alt_string_ack)
		else $error("string request not answered");
	a_enter_bb: assert property ($rose(billboard_mode) |-> $rose(dev_connect))
		else $error("billboard shown without reconnect");
	a_leave_bb: assert property ($fell(billboard_mode) |-> $fell(dev_connect))
		else $error("billboard left without detach");
	a_hold_len: assert property ($rose(dev_connect) |-> low_cnt == HOLD_CYCLES)
		else $error("detach length wrong");
endmodule : bac_monitor

bind bac_top bac_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.alt_string_req(alt_string_req), .alt_string_ack(alt_string_ack),
	.dev_connect(dev_connect), .billboard_mode(billboard_mode), .otp_msg_sel(otp_msg_sel));

`default_nettype wire

// ===== sim/bac_partner.sv
// model of the power delivery controller and the upstream host
// assumes the bench commands failures and string requests on hclk
`default_nettype none

module bac_partner (
	// clock
	input  wire logic hclk,
	// bench commands
	input  wire logic fail,
	input  wire logic str_go,
	// hub side
	input  wire logic billboard_mode,
	input  wire logic dev_connect,
	output logic      fail_n,
	output logic      usb_addr_set,
	output logic      alt_string_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic up = 1'b0;

	// outputs settle at the first edge, well inside the bench's reset
	// host addresses the device as soon as it attaches in billboard mode
	always @(posedge hclk) begin
		fail_n <= !fail;
		up <= billboard_mode && dev_connect;
		usb_addr_set <= billboard_mode && dev_connect && !up;
		alt_string_req <= str_go && billboard_mode;
	end
endmodule : bac_partner

`default_nettype wire

// ===== sim/test_billboard_attach_control.sv
// testbench of the billboard attach control block
// assumes bac_top, bac_partner and the bound checker are compiled first
`default_nettype none

module test_billboard_attach_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, dev_connect, billboard_mode;
	logic        alt_string_ack, otp_msg_sel, usb_addr_set, alt_string_req, fail_n;
	logic [1:0]  bm_configured;
	logic [71:0] gpio_in;
	logic        fail = 1'b0;
	logic        str_go = 1'b0;
	int          fpin = 68;
	int          err_total = 0;
	int          checks_done = 0;
	int          n;
	logic [7:0]  rv;
	logic [31:0] ra [7] = '{32'h10, 32'h104f0, 32'h104f4, 32'h104f8, 32'h104fc, 32'h10500,
		32'h500};
	logic [7:0]  re [7] = '{8'h14, 8'hd0, 8'h07, 8'hd0, 8'h07, 8'h00, 8'h00};

	always #4 hclk = ~hclk;
	assign gpio_in = ~({71'h0, ~fail_n} << fpin);

	bac_top #(.TICK_CYCLES(20), .HOLD_CYCLES(8)) DUT (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .gpio_in(gpio_in),
		.usb_addr_set(usb_addr_set), .alt_string_req(alt_string_req),
		.dev_connect(dev_connect), .billboard_mode(billboard_mode),
		.alt_string_ack(alt_string_ack), .otp_msg_sel(otp_msg_sel),
		.bm_configured(bm_configured));
	bac_partner HOST (.hclk(hclk), .fail(fail), .str_go(str_go),
		.billboard_mode(billboard_mode), .dev_connect(dev_connect), .fail_n(fail_n),
		.usb_addr_set(usb_addr_set), .alt_string_req(alt_string_req));

	// ----
	// tasks
	// ----
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rv = hrdata[7:0];
	endtask : xfer

	// bounded wait; a timeout shows up as a level mismatch
	task automatic wt(ref logic s, input logic v);
		n = 0;
		while (s !== v && n < 3000) begin
			@(posedge hclk);
			n++;
		end
		chk("wait level", {7'h0, v}, {7'h0, s});
	endtask : wt

	task automatic sess(input int pin, input logic [7:0] ctl);
		fail <= 1'b0;
		xfer(1'b1, 32'h10, ctl);
		repeat (5) @(posedge hclk);
		fpin = pin;
		fail <= 1'b1;
		wt(dev_connect, 1'b0);
		chk("mode in detach", 8'h0, {7'h0, billboard_mode});
		wt(billboard_mode, 1'b1);
		chk("connect", 8'h1, {7'h0, dev_connect});
		chk("otp message", 8'h1, {7'h0, otp_msg_sel});
		chk("configured code", 8'h0, {6'h0, bm_configured});
	endtask : sess

	task automatic leave(input int lo, input int hi);
		wt(billboard_mode, 1'b0);
		chk("span", 8'h1, {7'h0, n >= lo && n <= hi});
		wt(dev_connect, 1'b1);
		chk("standard mode", 8'h0, {7'h0, billboard_mode});
	endtask : leave

	// ----
	// tests
	// ----
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ra[i]) begin
			xfer(1'b0, ra[i], 8'h0);
			chk("reset value", re[i], rv);
		end
		$display("test reset values done");
		fail <= 1'b1;
		repeat (60) @(posedge hclk);
		chk("disabled connect", 8'h1, {7'h0, dev_connect});
		chk("disabled mode", 8'h0, {7'h0, billboard_mode});
		$display("test disabled done");
		xfer(1'b1, 32'h104f0, 8'h03);
		xfer(1'b1, 32'h104f4, 8'h00);
		sess(68, 8'h15);
		leave(45, 64);
		repeat (60) @(posedge hclk);
		chk("no rearm", 8'h0, {7'h0, billboard_mode});
		$display("test timer a done");
		xfer(1'b1, 32'h104f8, 8'h02);
		xfer(1'b1, 32'h104fc, 8'h00);
		xfer(1'b1, 32'h104f0, 8'hff);
		sess(68, 8'h15);
		str_go <= 1'b1;
		@(posedge hclk);
		str_go <= 1'b0;
		leave(25, 44);
		$display("test timer b done");
		xfer(1'b1, 32'h10, 8'hd3);
		xfer(1'b0, 32'h10, 8'h00);
		chk("control", 8'h15, rv);
		sess(1, 8'h03);
		xfer(1'b1, 32'h10, 8'h02);
		leave(0, 40);
		$display("test select done");
		xfer(1'b1, 32'h10500, 8'h01);
		xfer(1'b0, 32'h10500, 8'h00);
		chk("desc config", 8'h01, rv);
		chk("configured out", 8'h01, {6'h0, bm_configured});
		$display("test descriptor config done");
		conclude();
	end

	initial begin
		#(20000 * 8);
		err_total++;
		conclude();
	end
endmodule : test_billboard_attach_control

`default_nettype wire
